/* hw/fault_flag_regs.svh */
/*
  Register offsets, field positions and reset values of the fault event flag bank.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef FAULT_FLAG_REGS_SVH
`define FAULT_FLAG_REGS_SVH

`define BUCK_FAULT_STATUS_OFS 12'h000
`define BUCK_FAULT_MASK_OFS   12'h004
`define BUCK_FAULT_SENSE_OFS  12'h008
`define MISC_FAULT_STATUS_OFS 12'h00C
`define MISC_FAULT_MASK_OFS   12'h010
`define MISC_FAULT_SENSE_OFS  12'h014

`define BUCK3_BIT   3'd4
`define BUCK2_BIT   3'd3
`define BUCK1B_BIT  3'd1
`define BUCK1A_BIT  3'd0
`define FUSE_ERR_BIT  3'd7
`define FUSE_DONE_BIT 3'd6
`define OVERVOLT_BIT  3'd2
`define BOOST_BIT     3'd0

`define BUCK_USED_BITS 8'h1B
`define MISC_USED_BITS 8'hC5
`define STATUS_RESET   8'h00
`define MASK_RESET     8'hFF

`endif

/* hw/fault_flag_pkg.sv */
/*
  Types shared by the fault event flag bank.
  Assumes the register header is on the include path.
*/
package fault_flag_pkg;
  typedef logic [7:0]  reg8_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
endpackage : fault_flag_pkg

/* hw/fault_event_flag_bank.sv */
/*
  Fault event flag bank: two groups of sticky status, mask and live sense
  registers behind an APB slave, with an active-low interrupt output.
  Assumes the condition inputs come from analog monitors outside this clock
  domain and are synchronised here; the APB master runs on core_clk_in.
*/
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fault_flag_regs.svh"

module fault_event_flag_bank (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire fault_flag_pkg::addr_t paddr_in,
  input  wire fault_flag_pkg::word_t pwdata_in,
  input  wire logic [3:0]           pstrb_in,
  input  wire logic                 buck_three_limit_in,
  input  wire logic                 buck_two_limit_in,
  input  wire logic                 buck_one_phase_b_limit_in,
  input  wire logic                 buck_one_phase_a_limit_in,
  input  wire logic                 fuse_error_in,
  input  wire logic                 fuse_burn_running_in,
  input  wire logic                 frontend_supply_overvoltage_in,
  input  wire logic                 boost_converter_limit_in,
  output fault_flag_pkg::word_t     prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  output logic                      irq_out_n
);
  import fault_flag_pkg::*;

  // Raw condition vectors laid out at their register bit positions.
  reg8_t buck_raw;
  reg8_t misc_raw;
  reg8_t buck_sync1;
  reg8_t misc_sync1;
  reg8_t buck_sense;
  reg8_t misc_sense;
  reg8_t buck_sense_d;
  reg8_t misc_sense_d;
  reg8_t buck_fault_status;
  reg8_t buck_fault_mask;
  reg8_t misc_fault_status;
  reg8_t misc_fault_mask;
  reg8_t buck_set;
  reg8_t misc_set;
  reg8_t buck_clr;
  reg8_t misc_clr;
  reg8_t next_buck_status;
  reg8_t next_misc_status;
  logic  sense_primed;
  logic  access;
  logic  wr_lane0;

  // Returns one when the address names a mapped register.
  function automatic logic is_mapped(input addr_t a);
    if (a == `BUCK_FAULT_STATUS_OFS || a == `BUCK_FAULT_MASK_OFS || a == `BUCK_FAULT_SENSE_OFS) begin
      return 1'b1;
    end else if (a == `MISC_FAULT_STATUS_OFS || a == `MISC_FAULT_MASK_OFS || a == `MISC_FAULT_SENSE_OFS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  // Places each monitored condition at its documented bit.
  always_comb begin
    buck_raw = 8'h00;
    misc_raw = 8'h00;
    buck_raw[`BUCK3_BIT]     = buck_three_limit_in;
    buck_raw[`BUCK2_BIT]     = buck_two_limit_in;
    buck_raw[`BUCK1B_BIT]    = buck_one_phase_b_limit_in;
    buck_raw[`BUCK1A_BIT]    = buck_one_phase_a_limit_in;
    misc_raw[`FUSE_ERR_BIT]  = fuse_error_in;
    misc_raw[`FUSE_DONE_BIT] = fuse_burn_running_in;
    misc_raw[`OVERVOLT_BIT]  = frontend_supply_overvoltage_in;
    misc_raw[`BOOST_BIT]     = boost_converter_limit_in;
  end

  // Two-stage synchronisers; reset is not applied so that the sense registers
  // show the real regulator state straight after reset.
  // live sense path
  always_ff @(posedge core_clk_in) begin
    buck_sync1 <= buck_raw;
    misc_sync1 <= misc_raw;
    buck_sense <= buck_sync1;
    misc_sense <= misc_sync1;
  end

  // Previous sense values, for edge detection of the fuse burn end.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      buck_sense_d <= 8'h00;
      misc_sense_d <= 8'h00;
      sense_primed <= 1'b0;
    end else begin
      buck_sense_d <= buck_sense;
      misc_sense_d <= misc_sense;
      sense_primed <= 1'b1;
    end
  end

  assign access   = psel_in & penable_in & pready_out;
  assign wr_lane0 = access & pwrite_in & pstrb_in[0];

  // Flag set terms: level conditions set while active, fuse done on the fall
  // of the running indication.
  always_comb begin
    buck_set = buck_sense & `BUCK_USED_BITS;
    misc_set = misc_sense & `MISC_USED_BITS;
    misc_set[`FUSE_DONE_BIT] = sense_primed & misc_sense_d[`FUSE_DONE_BIT] & ~misc_sense[`FUSE_DONE_BIT];
    buck_clr = (wr_lane0 && paddr_in == `BUCK_FAULT_STATUS_OFS) ? pwdata_in[7:0] : 8'h00;
    misc_clr = (wr_lane0 && paddr_in == `MISC_FAULT_STATUS_OFS) ? pwdata_in[7:0] : 8'h00;
    next_buck_status = ((buck_fault_status & ~buck_clr) | buck_set) & `BUCK_USED_BITS;
    next_misc_status = ((misc_fault_status & ~misc_clr) | misc_set) & `MISC_USED_BITS;
  end

  // Sticky status flags.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      buck_fault_status <= `STATUS_RESET;
      misc_fault_status <= `STATUS_RESET;
    end else begin
      buck_fault_status <= next_buck_status;
      misc_fault_status <= next_misc_status;
    end
  end

  // Mask registers; all masked after reset so nothing interrupts until enabled.
  // buck mask layout
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      buck_fault_mask <= `MASK_RESET & `BUCK_USED_BITS;
      misc_fault_mask <= `MASK_RESET & `MISC_USED_BITS;
    end else if (wr_lane0 && paddr_in == `BUCK_FAULT_MASK_OFS) begin
      buck_fault_mask <= pwdata_in[7:0] & `BUCK_USED_BITS;
    end else if (wr_lane0 && paddr_in == `MISC_FAULT_MASK_OFS) begin
      misc_fault_mask <= pwdata_in[7:0] & `MISC_USED_BITS;
    end
  end

  // Interrupt from registered flags and masks, one cycle behind them.
  // mask gating
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(|(buck_fault_status & ~buck_fault_mask) | |(misc_fault_status & ~misc_fault_mask));
    end
  end

  // APB slave: one wait state, pready pulses in the second access cycle.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
    end
  end

  // Read data and error; sense reads are read-only and writes to them are dropped.
  // buck sense bits
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in & penable_in & ~pready_out) begin
      pslverr_out <= ~is_mapped(paddr_in);
      if (pwrite_in) begin
        prdata_out <= 32'h0000_0000;
      end else if (paddr_in == `BUCK_FAULT_STATUS_OFS) begin
        prdata_out <= {24'h00_0000, buck_fault_status};
      end else if (paddr_in == `BUCK_FAULT_MASK_OFS) begin
        prdata_out <= {24'h00_0000, buck_fault_mask};
      end else if (paddr_in == `BUCK_FAULT_SENSE_OFS) begin
        prdata_out <= {24'h00_0000, buck_sense & `BUCK_USED_BITS};
      end else if (paddr_in == `MISC_FAULT_STATUS_OFS) begin
        prdata_out <= {24'h00_0000, misc_fault_status};
      end else if (paddr_in == `MISC_FAULT_MASK_OFS) begin
        prdata_out <= {24'h00_0000, misc_fault_mask};
      end else if (paddr_in == `MISC_FAULT_SENSE_OFS) begin
        prdata_out <= {24'h00_0000, misc_sense & `MISC_USED_BITS};
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end else begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  // A set flag stays until a write of one to it.
  sticky_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (buck_fault_status[`BUCK3_BIT] && !(wr_lane0 && paddr_in == `BUCK_FAULT_STATUS_OFS))
    |=> buck_fault_status[`BUCK3_BIT])
    else $error("buck three flag dropped without clear");

  // Second buck current limit seen by the sense stage sets its flag next edge.
  buck_two_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    buck_sense[`BUCK2_BIT] |=> buck_fault_status[`BUCK2_BIT])
    else $error("buck two flag not set");

  // Phase B current limit sets its flag next edge.
  phase_b_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    buck_sense[`BUCK1B_BIT] |=> buck_fault_status[`BUCK1B_BIT])
    else $error("phase B flag not set");

  // Phase A current limit sets its flag next edge.
  phase_a_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    buck_sense[`BUCK1A_BIT] |=> buck_fault_status[`BUCK1A_BIT])
    else $error("phase A flag not set");

  // Boost current limit sets its flag next edge.
  boost_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    misc_sense[`BOOST_BIT] |=> misc_fault_status[`BOOST_BIT])
    else $error("boost flag not set");

  // The end of fuse burning, not its level, sets the completion flag.
  burn_done_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (sense_primed && $fell(misc_sense[`FUSE_DONE_BIT])) |=> misc_fault_status[`FUSE_DONE_BIT])
    else $error("burn done flag not set");

  // An unmasked misc flag pulls the interrupt low one edge later.
  irq_level_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (|(misc_fault_status & ~misc_fault_mask)) |=> !irq_out_n)
    else $error("interrupt not asserted for unmasked flag");

  // With every set flag masked the interrupt stays released.
  irq_masked_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((buck_fault_status & ~buck_fault_mask) == 8'h00 && (misc_fault_status & ~misc_fault_mask) == 8'h00)
    |=> irq_out_n)
    else $error("interrupt asserted with all flags masked");

  // Bit positions without a condition never hold a one.
  unused_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (buck_fault_status & ~`BUCK_USED_BITS) == 8'h00 && (misc_fault_mask & ~`MISC_USED_BITS) == 8'h00)
    else $error("unused bit set");

  // Every access gets exactly one wait state and a one-cycle ready.
  ready_pulse_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (psel_in && penable_in && !pready_out) |=> pready_out ##1 !pready_out)
    else $error("pready not a single pulse");

  // Flag setting and clearing checked against the sense stage; the read-back path against the raw pins.
  // Third buck current limit seen by the sense stage sets its flag next edge.
  buck_three_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    buck_sense[`BUCK3_BIT] |=> buck_fault_status[`BUCK3_BIT])
    else $error("buck three flag not set");

  // A fuse memory error sets its flag next edge.
  fuse_err_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    misc_sense[`FUSE_ERR_BIT] |=> misc_fault_status[`FUSE_ERR_BIT])
    else $error("fuse error flag not set");

  // Front-end supply overvoltage sets its flag next edge.
  overvolt_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    misc_sense[`OVERVOLT_BIT] |=> misc_fault_status[`OVERVOLT_BIT])
    else $error("overvoltage flag not set");

  // While burning still runs the completion flag must not appear.
  burn_no_level_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (misc_sense[`FUSE_DONE_BIT] && !misc_fault_status[`FUSE_DONE_BIT]) |=> !misc_fault_status[`FUSE_DONE_BIT])
    else $error("burn done flag set while burning");

  // Writing one to a flag whose condition is gone clears it.
  clear_one_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_lane0 && paddr_in == `BUCK_FAULT_STATUS_OFS && pwdata_in[`BUCK2_BIT] && !buck_sense[`BUCK2_BIT])
    |=> !buck_fault_status[`BUCK2_BIT])
    else $error("buck two flag not cleared by one");

  // An unmasked buck flag pulls the interrupt low one edge later.
  irq_buck_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (|(buck_fault_status & ~buck_fault_mask)) |=> !irq_out_n)
    else $error("interrupt not asserted for unmasked buck flag");

  // Reset releases the interrupt and idles the bus outputs.
  irq_reset_a: assert property (@(posedge core_clk_in)
    rst_in |=> (irq_out_n && !pready_out && !pslverr_out))
    else $error("outputs not idle after reset");

  // The buck mask changes only on a strobed write to its offset.
  mask_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(wr_lane0 && paddr_in == `BUCK_FAULT_MASK_OFS) |=> $stable(buck_fault_mask))
    else $error("buck mask changed without write");

  // A write without lane zero strobe leaves the misc mask alone.
  unstrobed_drop_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (access && pwrite_in && !pstrb_in[0] && paddr_in == `MISC_FAULT_MASK_OFS)
    |=> $stable(misc_fault_mask))
    else $error("unstrobed write changed misc mask");

  // Buck sense read returns the pins as they stood three edges before the data.
  buck_sense_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == `BUCK_FAULT_SENSE_OFS)
    |=> (prdata_out[`BUCK3_BIT] == $past(buck_three_limit_in, 3) && prdata_out[`BUCK2_BIT] == $past(buck_two_limit_in, 3)
    && prdata_out[`BUCK1B_BIT] == $past(buck_one_phase_b_limit_in, 3)
    && prdata_out[`BUCK1A_BIT] == $past(buck_one_phase_a_limit_in, 3)))
    else $error("buck sense read mismatch");

  // Misc sense bit 6 reads the running indication of fuse burning.
  burn_sense_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == `MISC_FAULT_SENSE_OFS)
    |=> prdata_out[`FUSE_DONE_BIT] == $past(fuse_burn_running_in, 3))
    else $error("burn running sense mismatch");

  // Misc sense bit 7 reads the fuse error condition.
  fuse_err_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == `MISC_FAULT_SENSE_OFS)
    |=> prdata_out[`FUSE_ERR_BIT] == $past(fuse_error_in, 3))
    else $error("fuse error sense mismatch");

  // Misc sense bits 0 and 2 read boost limit and overvoltage.
  misc_sense_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == `MISC_FAULT_SENSE_OFS)
    |=> (prdata_out[`BOOST_BIT] == $past(boost_converter_limit_in, 3)
    && prdata_out[`OVERVOLT_BIT] == $past(frontend_supply_overvoltage_in, 3)))
    else $error("boost or overvoltage sense mismatch");

  // Registers are eight bits wide; the upper read lanes are always zero.
  read_upper_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pready_out |-> prdata_out[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

  // An error response is only given together with ready.
  err_with_ready_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pslverr_out |-> pready_out)
    else $error("slave error without ready");

  // Main scenarios the tests should reach.
  clear_cov: cover property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(buck_fault_status[`BUCK2_BIT]));
  irq_cov: cover property (@(posedge core_clk_in) disable iff (rst_in) $fell(irq_out_n));
  burn_cov: cover property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(misc_fault_status[`FUSE_DONE_BIT]));
  release_cov: cover property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(irq_out_n));
  err_cov: cover property (@(posedge core_clk_in) disable iff (rst_in)
    pslverr_out);

endmodule : fault_event_flag_bank

/* sim/tb.sv */
/*
  Self-checking bench for the fault event flag bank: APB read and write tasks,
  condition inputs driven per event, and the interrupt line observed directly.
  Assumes the design files and the register header are on the include path.
*/
`timescale 1ns/1ps
`include "fault_flag_regs.svh"
module tb;
  import fault_flag_pkg::*;
  logic       core_clk_in;
  logic       rst_in;
  logic       psel;
  logic       pen;
  logic       pwr;
  logic [3:0] pstrb;
  addr_t      paddr;
  word_t      pwdata;
  word_t      prdata;
  logic       pready;
  logic       pslverr;
  logic       irq_n;
  logic [7:0] cond;
  int         error_cnt;
  int         n_checks;
  logic [2:0] bit_pos [8] = '{3'd4, 3'd3, 3'd1, 3'd0, 3'd7, 3'd6, 3'd2, 3'd0};

  fault_event_flag_bank i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .buck_three_limit_in(cond[0]), .buck_two_limit_in(cond[1]),
    .buck_one_phase_b_limit_in(cond[2]), .buck_one_phase_a_limit_in(cond[3]),
    .fuse_error_in(cond[4]), .fuse_burn_running_in(cond[5]),
    .frontend_supply_overvoltage_in(cond[6]), .boost_converter_limit_in(cond[7]),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out_n(irq_n));

  // Free-running core clock at 100 MHz.
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so no signal is driven twice in one step.
  // The request stands until pready is sampled high; only the watchdog ends a hang.
  task automatic apb(input logic wr, input addr_t a, input word_t d, output word_t rd, output logic err);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge core_clk_in);
  endtask : apb

  task automatic wr(input addr_t a, input word_t d);
    word_t r;
    logic  e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input addr_t a, input word_t exp);
    word_t r;
    logic  e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, (a > `MISC_FAULT_SENSE_OFS)});
  endtask : rdchk

  task automatic end_of_test;
    $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // A hang is cut short well beyond the few hundred cycles the run needs.
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence: reset values, per-event flag walk, refusals, then a second reset.
  initial begin
    addr_t st;
    addr_t mk;
    addr_t sn;
    word_t bv;
    word_t used;
    rst_in    = 1'b1;
    psel      = 1'b0;
    pen       = 1'b0;
    pwr       = 1'b0;
    pstrb     = 4'h1;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    cond      = 8'h00;
    error_cnt = 0;
    n_checks  = 0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rdchk(`BUCK_FAULT_STATUS_OFS, 32'h0000_0000);
    rdchk(`BUCK_FAULT_MASK_OFS, 32'h0000_001B);
    rdchk(`MISC_FAULT_MASK_OFS, 32'h0000_00C5);
    rdchk(`MISC_FAULT_SENSE_OFS, 32'h0000_0000);
    chk({31'h0, irq_n}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      st = (i < 4) ? `BUCK_FAULT_STATUS_OFS : `MISC_FAULT_STATUS_OFS;
      mk = (i < 4) ? `BUCK_FAULT_MASK_OFS : `MISC_FAULT_MASK_OFS;
      sn = (i < 4) ? `BUCK_FAULT_SENSE_OFS : `MISC_FAULT_SENSE_OFS;
      used = (i < 4) ? 32'h0000_001B : 32'h0000_00C5;
      bv = 32'h0000_0001 << bit_pos[i];
      // while burning runs only the sense register is read, no fuse registers.
      cond[i] <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      rdchk(sn, bv);
      chk({31'h0, irq_n}, 32'h1);
      cond[i] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      rdchk(sn, 32'h0000_0000);
      rdchk(st, bv);
      wr(mk, used & ~bv);
      // The interrupt flop follows the new mask one edge after the write lands.
      @(posedge core_clk_in);
      chk({31'h0, irq_n}, 32'h0);
      wr(st, ~bv);
      rdchk(st, bv);
      wr(st, bv);
      rdchk(st, 32'h0000_0000);
      chk({31'h0, irq_n}, 32'h1);
      wr(mk, 32'hFFFF_FFFF);
      rdchk(mk, used);
    end
    // Refusals: sense is read-only, unmapped address errors, unstrobed write dropped.
    wr(`BUCK_FAULT_SENSE_OFS, 32'hFFFF_FFFF);
    rdchk(`BUCK_FAULT_SENSE_OFS, 32'h0000_0000);
    rdchk(12'h018, 32'h0000_0000);
    pstrb <= 4'h0;
    wr(`MISC_FAULT_MASK_OFS, 32'h0000_0000);
    pstrb <= 4'h1;
    rdchk(`MISC_FAULT_MASK_OFS, 32'h0000_00C5);
    // Second reset with a live fault: sense must follow the condition, not a constant.
    cond <= 8'h80;
    rst_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rdchk(`MISC_FAULT_SENSE_OFS, 32'h0000_0001);
    end_of_test();
  end
endmodule : tb
